// ==== drb_pkg.sv ====
// Purpose: Shared constants for the channel read-back serial slave.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Offsets are byte addresses.
`default_nettype none
package drb_pkg;
  // Register map offsets.
  localparam logic [7:0] TEMP_BASE_OFS = 8'h00;
  localparam logic [7:0] CONV_BASE_OFS = 8'h10;
  localparam logic [7:0] LOAD_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h24;
  // Width of one channel store.
  localparam int STORE_W = 12;
  // Reset value of every channel store.
  localparam logic [11:0] STORE_RST = 12'h000;
  // Fixed upper part of the seven-bit slave address.
  localparam logic [4:0] ADDR_PREFIX = 5'b1_0011;
  // Bits in one serial byte.
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Control byte field positions.
  localparam int CTL_EXT_HI = 7;
  localparam int CTL_EXT_LO = 6;
  localparam int CTL_LOAD_HI = 5;
  localparam int CTL_LOAD_LO = 4;
  localparam int CTL_CH_HI = 2;
  localparam int CTL_CH_LO = 1;
  localparam int CTL_FMT = 0;
  // Power-down field inside a channel store.
  localparam int PD_HI = 11;
  localparam int PD_LO = 10;
  // Filler for the low six bits of the power-down byte.
  localparam logic [5:0] PD_FILL = 6'h3F;
  // Filler for the undefined low bits of the low data byte.
  localparam logic [5:0] LOW_FILL = 6'h00;
  // Serial engine states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_RX = 5'b0_0010,
    ST_ACK = 5'b0_0100,
    ST_TX = 5'b0_1000,
    ST_MACK = 5'b1_0000
  } drb_state_t;
  // Which byte of a write the receiver expects.
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CTRL = 2'b01,
    PH_DATA = 2'b10
  } drb_phase_t;
endpackage
`default_nettype wire

// ==== drb_readback.sv ====
// Purpose: Two-wire slave read-back of four channel stores, APB access.
// Assumes: Bus clock and data are slow against sys_clk_i (8+ samples).
// Notes: Write data bytes after the control byte are acked, not stored.
`timescale 1ns/10ps
`default_nettype none
module drb_readback #(
  parameter int CHANNELS = 4
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Two-wire bus, open drain data line.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Address-select pins.
  input wire logic [1:0] pin_addr_i,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Per-channel output-stage state.
  output logic [CHANNELS-1:0] out_hiz_o,
  output logic [CHANNELS-1:0] out_1k_o,
  output logic [CHANNELS-1:0] out_100k_o
);
  import drb_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection.

  // Two-stage synchronisers; only the second stage feeds logic.
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  // Delayed copy of the synchronised clock and data.
  logic scl_d_ff;
  logic sda_d_ff;

  // Every pin passes two flops; clock and data pass one more for edge detection. The bus
  // lines reset to their idle-high level, so release gives no false edge.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_ff <= 4'h3;
      sync2_ff <= 4'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      sync1_ff <= {pin_addr_i, sda_i, scl_i};
      sync2_ff <= sync1_ff;
      scl_d_ff <= sync2_ff[0];
      sda_d_ff <= sync2_ff[1];
    end
  end

  // Clean bus views.
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_s = sync2_ff[0];
  assign sda_s = sync2_ff[1];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  // Data falling while the clock is high is a start or repeated start.
  assign start_seen = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  // Data rising while the clock is high is a stop.
  assign stop_seen = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  //////////////////////////////////////////////////////////////////////
  // Channel stores.

  // Temporary and converter stores, both twelve bits.
  logic [STORE_W-1:0] temp_ff [CHANNELS];
  logic [STORE_W-1:0] conv_ff [CHANNELS];
  // APB write strobe at the completing edge.
  logic apb_wr;
  assign apb_wr = psel & penable & pready & pwrite;

  // Software fills the temporary stores and then loads converters.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        temp_ff[i] <= STORE_RST;
        conv_ff[i] <= STORE_RST;
      end
    end else if (apb_wr) begin
      for (int i = 0; i < CHANNELS; i++) begin
        // Whole twelve bits kept, power-down in 11..10.
        if (paddr == TEMP_BASE_OFS + 8'(4 * i)) begin
          temp_ff[i] <= pwdata[STORE_W-1:0];
        end
        if (paddr == LOAD_OFS && pwdata[i]) begin
          conv_ff[i] <= temp_ff[i];
        end
      end
    end
  end

  // Output stage decode of the stored power-down mode.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_hiz_o <= '0;
      out_1k_o <= '0;
      out_100k_o <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        // Both 00 and 11 leave the output open.
        out_hiz_o[i] <= ~(conv_ff[i][PD_HI] ^ conv_ff[i][PD_LO]);
        out_1k_o[i] <= ~conv_ff[i][PD_HI] & conv_ff[i][PD_LO];
        out_100k_o[i] <= conv_ff[i][PD_HI] & ~conv_ff[i][PD_LO];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Serial engine.

  drb_state_t state_ff;
  drb_phase_t phase_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] ctrl_ff;
  logic rw_ff;
  logic [1:0] byte_idx_ff;
  logic mack_ff;

  // Builds the transmit byte for a position in the read sequence.
  function automatic logic [7:0] tx_byte(input logic [STORE_W-1:0] st,
                                         input logic fmt,
                                         input logic [1:0] idx);
    logic [1:0] pos;
    pos = fmt ? idx : idx + 2'd1;
    case (pos)
      2'd0: tx_byte = {st[PD_HI], st[PD_LO], PD_FILL};
      2'd1: tx_byte = st[9:2];
      default: tx_byte = {st[1:0], LOW_FILL};
    endcase
  endfunction

  // Selected channel from the stored control byte.
  logic [STORE_W-1:0] sel_store;
  assign sel_store = conv_ff[ctrl_ff[CTL_CH_HI:CTL_CH_LO]];
  // Index of the last byte: 1 for two bytes, 2 for three.
  logic [1:0] last_idx;
  assign last_idx = ctrl_ff[CTL_FMT] ? 2'd2 : 2'd1;
  // Next byte to send: the first after the read ack, else the following.
  logic [7:0] nxt_tx;
  assign nxt_tx = tx_byte(sel_store, ctrl_ff[CTL_FMT],
                          (state_ff == ST_MACK) ? byte_idx_ff + 2'd1 : 2'd0);

  // Main protocol sequencer.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_ADDR;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ctrl_ff <= 8'h00;
      rw_ff <= 1'b0;
      byte_idx_ff <= 2'd0;
      mack_ff <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0; // Open drain: the data output only ever pulls low.
    end else if (stop_seen) begin
      // A stop ends everything and releases the line.
      state_ff <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (start_seen) begin
      // Start or repeated start: expect an address byte.
      state_ff <= ST_RX;
      phase_ff <= PH_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_o <= 1'b0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (scl_rise && bit_cnt_ff != BYTE_BITS) begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == BYTE_BITS) begin
            if (phase_ff == PH_ADDR) begin
              // Master code and foreign addresses miss here.
              if (shift_ff[7:1] == {ADDR_PREFIX, sync2_ff[3:2]}) begin
                rw_ff <= shift_ff[0];
                state_ff <= ST_ACK;
                sda_oe_o <= 1'b1;
              end else begin
                state_ff <= ST_IDLE;
              end
            end else begin
              if (phase_ff == PH_CTRL) begin
                ctrl_ff <= shift_ff;
              end
              state_ff <= ST_ACK;
              sda_oe_o <= 1'b1;
            end
          end
        end
        ST_ACK: begin
          // Ack bit held low until the master clocks it out.
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (rw_ff) begin
              state_ff <= ST_TX;
              byte_idx_ff <= 2'd0;
              shift_ff <= nxt_tx;
              sda_oe_o <= ~nxt_tx[7];
            end else begin
              state_ff <= ST_RX;
              sda_oe_o <= 1'b0;
              // Written bytes step the phase: address, then control, then data.
              if (phase_ff == PH_ADDR) begin
                phase_ff <= PH_CTRL;
              end else begin
                phase_ff <= PH_DATA;
              end
            end
          end
        end
        ST_TX: begin
          // Drive the next bit after each falling clock edge.
          if (scl_fall) begin
            if (bit_cnt_ff == BYTE_BITS - 4'h1) begin
              state_ff <= ST_MACK;
              sda_oe_o <= 1'b0;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b1};
              sda_oe_o <= ~shift_ff[6];
            end
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_ff <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (!mack_ff || byte_idx_ff == last_idx) begin
              // Not-acknowledge or end of sequence: let go.
              state_ff <= ST_IDLE;
              sda_oe_o <= 1'b0;
            end else begin
              state_ff <= ST_TX;
              byte_idx_ff <= byte_idx_ff + 2'd1;
              shift_ff <= nxt_tx;
              sda_oe_o <= ~nxt_tx[7];
            end
          end
        end
        default: begin
          // Idle waits for a start; line stays released.
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // APB slave: one wait state on every transfer.

  logic [31:0] rd_word;
  logic rd_err;

  // Read mux and unmapped-address detection.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b1;
    if (paddr == LOAD_OFS) begin
      rd_err = 1'b0;
    end else if (paddr == STATUS_OFS) begin
      rd_word = {18'h0_0000, rw_ff, state_ff, ctrl_ff};
      rd_err = 1'b0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (paddr == TEMP_BASE_OFS + 8'(4 * i)) begin
          rd_word = {20'h0_0000, temp_ff[i]};
          rd_err = 1'b0;
        end
        if (paddr == CONV_BASE_OFS + 8'(4 * i)) begin
          rd_word = {20'h0_0000, conv_ff[i]};
          rd_err = 1'b0;
        end
      end
    end
    // Converter stores are read only.
    if (pwrite && paddr >= CONV_BASE_OFS && paddr < LOAD_OFS) begin
      rd_err = 1'b1;
    end
    if (pwrite && paddr == STATUS_OFS) begin
      rd_err = 1'b1;
    end
  end

  // Answer registered so every bus output comes from a flop.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= rd_err;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== drb_readback_props.sv ====
// Purpose: Port-level checks of the channel read-back slave.
// Assumes: Sampling on sys_clk_i, reset active low.
// Notes: Attached by the bind below the module.
`timescale 1ns/10ps
`default_nettype none
module drb_readback_props #(
  parameter int CHANNELS = 4
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CHANNELS-1:0] out_hiz_o,
  input wire logic [CHANNELS-1:0] out_1k_o,
  input wire logic [CHANNELS-1:0] out_100k_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Setup cycle, then the first access cycle.
  sequence apb_access;
    psel && !penable ##1 psel && penable;
  endsequence
  // Data line rises while the bus clock stays high.
  sequence stop_seen;
    scl_i && !sda_i ##1 scl_i && sda_i;
  endsequence
  a_sda_open_drain: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  a_ready_wait: assert property (apb_access |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_needs_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_unmapped: assert property (pready && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access accepted");
  a_err_data_zero: assert property (pready && pslverr |-> prdata == 0)
    else $error("refused read returned data");
  a_mode_onehot: assert property ($past(resetn_i) |->
    (out_hiz_o ^ out_1k_o ^ out_100k_o) == '1 &&
    (out_hiz_o & out_1k_o | out_hiz_o & out_100k_o) == '0)
    else $error("output stage state not one-hot");
  // Bits change only while the bus clock is low, so they stand at rise.
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed with clock high");
  a_idle_stop: assert property (stop_seen |=> !sda_oe_o [*8])
    else $error("data line driven after stop");
endmodule
bind drb_readback drb_readback_props #(.CHANNELS(CHANNELS))
  drb_readback_props_i (
  .sys_clk_i, .resetn_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .out_hiz_o, .out_1k_o,
  .out_100k_o);
`default_nettype wire

// ==== drb_i2c_master.sv ====
// Purpose: Behavioural two-wire bus master for the read-back slave.
// Assumes: 400 ns bus clock period, pull-up on the data line.
// Notes: High-speed framing keeps the same pace; sampling limits it.
`timescale 1ns/10ps
`default_nettype none
module drb_i2c_master (
  input wire logic sda_oe_i,
  output logic scl_o,
  output wire logic sda_o
);
  logic low = 1'b0; // High while the master pulls the data line.
  initial scl_o = 1'b1; // Clock stands high outside frames.
  // Pull-up: the line is low only while someone pulls it.
  assign sda_o = ~(low | sda_oe_i);
  // Clock low 250 ns so the slave's late bit changes settle first.
  task automatic bit_io(input logic b, output logic r);
    #150 low = ~b;
    #100 scl_o = 1'b1;
    #100 r = sda_o;
    #50 scl_o = 1'b0;
  endtask
  task automatic start();
    #150 low = 1'b0;
    #100 scl_o = 1'b1;
    #100 low = 1'b1;
    #50 scl_o = 1'b0;
  endtask
  task automatic stop();
    #150 low = 1'b1;
    #100 scl_o = 1'b1;
    #100 low = 1'b0;
    #100;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Acks the byte when ack is set, else refuses it; the caller refuses the last one.
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, r);
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the channel read-back slave.
// Assumes: 20 MHz clock, APB store loading, seed 71.
// Notes: Stores are loaded over APB, then read back on the bus.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import drb_pkg::*;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, scl, sda_oe;
  wire logic sda;
  logic [1:0] pins = 2'b00;
  logic [3:0] hiz, k1, k100;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  drb_readback drb_readback_i (.sys_clk_i, .resetn_i, .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .pin_addr_i(pins), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .out_hiz_o(hiz), .out_1k_o(k1), .out_100k_o(k100));
  drb_i2c_master drb_i2c_master_i (.sda_oe_i(sda_oe), .scl_o(scl),
    .sda_o(sda));
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hung handshake ends the run as a failure.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Request held until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Byte k of a read-back of store s in format f.
  function automatic logic [7:0] exp_byte(input logic [11:0] s,
                                          input logic f, input int k);
    if (f && k == 0) return {s[PD_HI], s[PD_LO], PD_FILL};
    if (k == int'(f)) return s[9:2];
    return {s[1:0], LOW_FILL};
  endfunction
  task automatic readback(input logic [1:0] ch, input logic f,
                          input logic hs, input logic [11:0] s);
    logic ack;
    logic [7:0] d;
    logic [7:0] ctl;
    ctl = {2'($urandom), 2'b00, 1'($urandom), ch, f};
    #13;
    if (hs) begin
      drb_i2c_master_i.start();
      drb_i2c_master_i.wbyte({5'b0_0001, 3'($urandom)}, ack);
      chk(ack, 1'b0);
    end
    drb_i2c_master_i.start();
    drb_i2c_master_i.wbyte({ADDR_PREFIX, pins, 1'b0}, ack);
    chk(ack, 1'b1);
    drb_i2c_master_i.wbyte(ctl, ack);
    chk(ack, 1'b1);
    drb_i2c_master_i.start();
    drb_i2c_master_i.wbyte({ADDR_PREFIX, pins, 1'b1}, ack);
    chk(ack, 1'b1);
    for (int k = 0; k < 2 + f; k++) begin
      drb_i2c_master_i.rbyte(k < 1 + f, d);
      chk(d, exp_byte(s, f, k));
    end
    drb_i2c_master_i.stop();
    chk(sda_oe, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic e;
    logic [11:0] s;
    logic [1:0] ch;
    void'($urandom(71));
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk(hiz, 4'hF);
    for (int c = 0; c < 4; c++) begin
      apb(1'b0, CONV_BASE_OFS + 8'(4 * c), 0, q, e);
      chk(q, 0);
    end
    apb(1'b0, 8'h30, 0, q, e);
    chk(e, 1'b1);
    apb(1'b1, CONV_BASE_OFS, 32'h0000_0155, q, e);
    chk(e, 1'b1);
    // First passes force every mode and both formats.
    for (int i = 0; i < 8; i++) begin
      ch = 2'($urandom);
      s = 12'($urandom);
      if (i < 4) s[11:10] = 2'(i);
      pins <= 2'($urandom);
      apb(1'b1, TEMP_BASE_OFS + 8'(4 * ch), 32'(s), q, e);
      apb(1'b1, LOAD_OFS, 32'(1) << ch, q, e);
      apb(1'b0, CONV_BASE_OFS + 8'(4 * ch), 0, q, e);
      chk(q, 32'(s));
      readback(ch, (i < 2) ? 1'(i) : 1'($urandom), i[0], s);
      chk({hiz[ch], k1[ch], k100[ch]}, {s[11] == s[10],
          s[11:10] == 2'b01, s[11:10] == 2'b10});
    end
    // Write framing with a data byte: acked, not stored; status shows the control byte.
    drb_i2c_master_i.start();
    drb_i2c_master_i.wbyte({ADDR_PREFIX, pins, 1'b0}, e);
    drb_i2c_master_i.wbyte(8'h5A, e);
    drb_i2c_master_i.wbyte(8'($urandom), e);
    chk(e, 1'b1);
    drb_i2c_master_i.stop();
    apb(1'b0, STATUS_OFS, 32'h0000_0000, q, e);
    chk(q, {18'h0_0000, 1'b0, ST_IDLE, 8'h5A});
    apb(1'b0, CONV_BASE_OFS + 8'(4 * ch), 32'h0000_0000, q, e);
    chk(q, 32'(s));
    drb_i2c_master_i.start();
    drb_i2c_master_i.wbyte({ADDR_PREFIX, ~pins, 1'b0}, e);
    chk(e, 1'b0);
    drb_i2c_master_i.stop();
    wrap_up();
  end
endmodule
`default_nettype wire
